// >>> dv/host_model.sv
// Register-bus host model standing in for the application processor.
`timescale 1ns/100ps
module host_model
  import pdo_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output reg_req_t        o_reg
);
  initial o_reg = '0;

  // Single-byte write; released fields show inverted values so stale data is never mistaken for valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk_sys);
    o_reg <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  // Single-byte read; the answer stands one cycle, so it is taken in that cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_clk_sys);
    o_reg <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk_sys);
    o_reg <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    ok = i_rvalid;
    d  = i_rdata;
  endtask
endmodule

// >>> dv/pdo_sequencer_asserts.sv
// Concurrent checks on the ports of the power-down order sequencer.
`timescale 1ns/100ps
module pdo_sequencer_asserts
  import pdo_pkg::*;
#(
  parameter int P_SUPPLIES    = 7,
  parameter int P_STEP_CYCLES = 2
)
(
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_clk_en,
  input wire reg_req_t   i_reg,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_rvalid,
  input wire logic       i_power_down,
  input wire logic [6:0] o_supply_en,
  input wire logic       o_seq_busy,
  input wire logic       o_seq_done
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // Two quiet cycles is the shortest pause, so this holds for any step length above one.
  sequence s_step_hold;
    $stable(o_supply_en)[*2];
  endsequence

  // An accepted start shows either as a running sequence or as an immediate finish.
  sequence s_started;
    ##1 (o_seq_busy || o_seq_done);
  endsequence

  a_read_answer: assert property (i_reg.rd && i_clk_en |=> o_reg_rvalid)
    else $error("read request got no answer");
  a_answer_cause: assert property (o_reg_rvalid && $past(i_clk_en) |-> $past(i_reg.rd))
    else $error("read answer without a request");
  a_unused_zero: assert property (o_reg_rvalid |-> o_reg_rdata[7:3] == 5'h00)
    else $error("unused bits read nonzero");
  a_done_pulse: assert property (o_seq_done && i_clk_en |=> !o_seq_done)
    else $error("done lasted more than one cycle");
  a_done_all_off: assert property (o_seq_done |-> o_supply_en == 7'h00)
    else $error("supply still on at done");
  a_pd_start: assert property (i_power_down && i_clk_en && !o_seq_busy && !o_seq_done |-> s_started)
    else $error("power-down request not taken");
  a_step_pause: assert property (o_seq_busy && o_supply_en != $past(o_supply_en) |=> s_step_hold)
    else $error("next supply dropped without a pause");
  a_seq_bounded: assert property ($rose(o_seq_busy) |-> ##[1:400] o_seq_done)
    else $error("sequence never finished");
endmodule

bind pdo_sequencer pdo_sequencer_asserts #(.P_SUPPLIES(P_SUPPLIES), .P_STEP_CYCLES(P_STEP_CYCLES))
  u_pdo_sequencer_asserts (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_reg(i_reg),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_power_down(i_power_down),
    .o_supply_en(o_supply_en), .o_seq_busy(o_seq_busy), .o_seq_done(o_seq_done));

// >>> dv/pdo_sequencer_test.sv
// Self-checking bench for the power-down order sequencer.
`timescale 1ns/100ps
module pdo_sequencer_test
  import pdo_pkg::*;
;
  localparam int STEP_CYCLES = 2;
  logic       i_clk_sys, i_rst_n, i_clk_en, i_system_on, i_supplies_on, i_power_down;
  logic       rvalid, busy, done, ok, busy_seen;
  logic [7:0] rdata, rd_val, lf;
  logic [6:0] en;
  order_vec_t i_fuse_order, ord;
  reg_req_t   i_reg;
  int         n_mismatch, samples_checked, t[7];

  pdo_sequencer #(.P_STEP_CYCLES(STEP_CYCLES)) u_pdo_sequencer (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en), .i_reg(i_reg), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_fuse_order(i_fuse_order), .i_system_on(i_system_on), .i_supplies_on(i_supplies_on),
    .i_power_down(i_power_down), .o_supply_en(en), .o_seq_busy(busy), .o_seq_done(done));
  host_model u_host_model (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_rvalid(rvalid), .o_reg(i_reg));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Relation of two values: 2 above, 1 equal, 0 below.
  function automatic logic [7:0] rel(input int a, input int b);
    return (a > b) ? 8'h02 : ((a == b) ? 8'h01 : 8'h00);
  endfunction

  // Expected cycle of a supply's drop: one cycle per level, plus the pause after a level that matched.
  function automatic int drop_cycle(input order_vec_t o, input int s);
    int   c;
    logic hit;
    c = 0;
    for (int lv = 7; lv >= 0; lv--)
    begin
      hit = 1'b0;
      foreach (o[k]) if (o[k] == 3'(lv)) hit = 1'b1;
      if (o[s] == 3'(lv)) return c + 1;
      c += hit ? (1 + STEP_CYCLES) : 1;
    end
    return -1;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    u_host_model.rd(a, rd_val, ok);
    check({7'h00, ok}, 8'h01);
    check(rd_val, exp);
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Power all supplies up, start the sequence and note the cycle in which each enable drops.
  task automatic run_down();
    foreach (t[i]) t[i] = -1;
    busy_seen = 1'b0;
    @(posedge i_clk_sys) i_supplies_on <= 1'b1;
    @(posedge i_clk_sys) i_supplies_on <= 1'b0;
    @(posedge i_clk_sys) i_power_down <= 1'b1;
    for (int c = 0; c < 100; c++)
    begin
      @(posedge i_clk_sys);
      i_power_down <= 1'b0;
      #1;
      busy_seen |= busy;
      foreach (t[i]) if (t[i] < 0 && en[i] === 1'b0) t[i] = c;
      if (done === 1'b1) break;
    end
  endtask

  initial
  begin
    #2000000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    i_rst_n = 1'b0;
    i_system_on = 1'b0;
    i_supplies_on = 1'b0;
    i_power_down = 1'b0;
    i_clk_en = 1'b1;
    lf = 8'h36;
    foreach (i_fuse_order[i])
    begin
      lf = lfsr(lf);
      i_fuse_order[i] = lf[2:0];
    end
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd_check(8'(8'h58 + i), {5'h00, i_fuse_order[i]});
      rd_check(8'(8'h5f + i), {5'h00, i_fuse_order[i]});
    end
    rd_check(8'h57, 8'h00);
    rd_check(8'h66, 8'h00);
    // Outside the system-on states a write must leave the field alone.
    u_host_model.wr(8'h63, 8'hff);
    rd_check(8'h63, {5'h00, i_fuse_order[4]});
    @(posedge i_clk_sys) i_system_on <= 1'b1;
    // With the clock enable low a write must not land, so the old field still reads back.
    i_clk_en <= 1'b0;
    u_host_model.wr(8'h63, {5'h00, ~i_fuse_order[4]});
    @(posedge i_clk_sys) i_clk_en <= 1'b1;
    rd_check(8'h63, {5'h00, i_fuse_order[4]});
    // Rounds of random orders with junk in the unused bits; the last round is all zero.
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 7; i++)
      begin
        lf = lfsr(lf);
        ord[i] = (r == 2) ? 3'h0 : lf[2:0];
        u_host_model.wr(8'(8'h5f + i), {lf[7:3], ord[i]});
        rd_check(8'(8'h5f + i), {5'h00, ord[i]});
        u_host_model.wr(8'(8'h58 + i), ~lf);
        rd_check(8'(8'h58 + i), {5'h00, i_fuse_order[i]});
      end
      run_down();
      for (int i = 0; i < 7; i++)
        for (int j = 0; j < 7; j++)
          check(rel(t[j], t[i]), rel(ord[i], ord[j]));
      for (int i = 0; i < 7; i++)
        check(8'(t[i]), 8'((ord == '0) ? 0 : drop_cycle(ord, i)));
      check({7'h00, busy_seen}, {7'h00, ord != '0});
      check({7'h00, done}, 8'h01);
      if (r == 2)
      begin
        check(8'(t[0]), 8'h00);
      end
    end
    conclude();
  end
endmodule

// >>> hw/pdo_order_store.sv
// Storage of the fused mirrors and the writable power-down order fields.
`timescale 1ns/100ps
`include "pdo_regs.svh"

module pdo_order_store
  import pdo_pkg::*;
#(
  parameter int P_SUPPLIES = 7
)
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_clk_en,
  input  wire order_vec_t i_fuse_order,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic [7:0]      o_rdata,
  output order_vec_t      o_off_order
);

  typedef struct packed
  {
    logic [NUM_ENTRIES-1:0][2:0] ent;
    logic [7:0]                  rdata;
  } store_t;

  store_t    st_r;
  store_t    st_nxt;
  addr_dec_t dec;

  if (P_SUPPLIES != NUM_SUPPLIES)
  begin : g_bad_supplies
    $error("pdo_order_store supports exactly seven supplies");
  end

  // Next value: writes touch only the power-down half, reads load the output byte.
  always_comb
  begin
    st_nxt = st_r;
    dec    = decode_addr(i_addr);
    if (i_wr_en && dec.writable)
    begin
      st_nxt.ent[dec.idx] = i_wdata[`PDO_ORDER_MSB:`PDO_ORDER_LSB]; // Upper bits dropped.
    end
    if (i_rd_en)
    begin
      st_nxt.rdata = dec.hit ? {`PDO_UNUSED_ZERO, st_r.ent[dec.idx]} : `PDO_READ_ZERO;
    end
  end

  // Reset is synchronous, so the fuse levels are sampled on a clock edge while held.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < NUM_SUPPLIES; i++)
      begin
        st_r.ent[i]              <= i_fuse_order[i]; // Mirror copy of the power-up order.
        st_r.ent[i+NUM_SUPPLIES] <= i_fuse_order[i]; // Off order starts equal to on order.
      end
      st_r.rdata <= `PDO_READ_ZERO;
    end
    else if (i_clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;

  // Seven separate three-bit fields feed the sequencer.
  for (genvar g = 0; g < NUM_SUPPLIES; g++)
  begin : g_off
    assign o_off_order[g] = st_r.ent[g+NUM_SUPPLIES];
  end

endmodule

// >>> hw/pdo_pkg.sv
// Types and decode helpers shared by the power-down order block.
`include "pdo_regs.svh"
package pdo_pkg;

  localparam int NUM_SUPPLIES = 7;
  localparam int NUM_ENTRIES  = 14;

  // Sequencer states.
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_STEP = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_state_t;

  // One register access from the processor side.
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Result of decoding an address into the entry table.
  typedef struct packed
  {
    logic       hit;
    logic       writable;
    logic [3:0] idx;
  } addr_dec_t;

  typedef logic [NUM_SUPPLIES-1:0][2:0] order_vec_t;

  // Entries 0..6 are mirrors, 7..13 are the writable power-down fields.
  function automatic addr_dec_t decode_addr(input logic [7:0] addr);
    addr_dec_t d;
    logic [7:0] off;
    off        = addr - `PDO_MIRROR_BASE;
    d.hit      = (addr >= `PDO_MIRROR_BASE) && (addr <= `PDO_LAST_OFS);
    d.idx      = off[3:0];
    d.writable = d.hit && (addr >= `PDO_SW1_OFF_OFS);
    return d;
  endfunction

endpackage

// >>> hw/pdo_regs.svh
// Offsets, reset values and timing constants of the power-down order block.
`ifndef PDO_REGS_SVH
`define PDO_REGS_SVH

// Read-only mirrors of the fused power-up order, one byte each.
`define PDO_MIRROR_BASE          8'h58
// Writable power-down order registers, switchers first, memory reference last.
`define PDO_SW1_OFF_OFS          8'h5f
`define PDO_SW2_OFF_OFS          8'h60
`define PDO_SW3_OFF_OFS          8'h61
`define PDO_LDO1_OFF_OFS         8'h62
`define PDO_LDO2_OFF_OFS         8'h63
`define PDO_LDO3_OFF_OFS         8'h64
`define PDO_VREF_OFF_OFS         8'h65
`define PDO_LAST_OFS             8'h65

// Field layout: order value in bits 2 to 0, bits 7 to 3 unused.
`define PDO_ORDER_MSB            2
`define PDO_ORDER_LSB            0
`define PDO_UNUSED_ZERO          5'h00
`define PDO_READ_ZERO            8'h00

// Printed reset value of a register that has no fuse behind it.
`define PDO_ORDER_RESET          3'h0
`define PDO_TOP_LEVEL            3'h7

// Pause between two power-down steps.
`define PDO_CLK_PERIOD_NS        100
`define PDO_STEP_TIME_NS         2000
`define PDO_STEP_CYCLES          ((`PDO_STEP_TIME_NS + `PDO_CLK_PERIOD_NS - 1) / `PDO_CLK_PERIOD_NS)

`endif

// >>> hw/pdo_sequencer.sv
// Power-down order sequencer with its register access for seven supplies.
// Supply index: 0..2 switchers, 3..5 linear regulators, 6 memory reference.
//
// Timing, counted from the edge that takes a power-down request:
// the busy flag rises and level 7 is looked at in the first cycle.
// A level that matches one or more supplies still on takes one cycle;
// their enables fall at the next edge, and the sequencer then pauses
// for P_STEP_CYCLES cycles before it looks at the next lower level.
// A level that matches nothing costs a single cycle, so a sparse
// order table does not stretch the run by empty pauses.
// After level 0 the done flag pulses for one cycle and busy falls.
// Supplies that share a level switch off in the same cycle.
//
// With every field at zero the stepping is skipped: all enables fall
// at the edge that takes the request, done pulses and busy never rises.
//
// Order fields cannot be written while a run is in progress. A host
// that rewrites them late must wait for the done pulse, or its write
// is dropped without notice; the trade buys a sequencer that never
// sees its table change half way through.
`timescale 1ns/100ps
`include "pdo_regs.svh"

module pdo_sequencer
  import pdo_pkg::*;
#(
  parameter int P_SUPPLIES    = 7,
  parameter int P_STEP_CYCLES = `PDO_STEP_CYCLES
)
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_clk_en,
  input  wire reg_req_t   i_reg,
  output logic [7:0]      o_reg_rdata,
  output logic            o_reg_rvalid,
  input  wire order_vec_t i_fuse_order,
  input  wire logic       i_system_on,
  input  wire logic       i_supplies_on,
  input  wire logic       i_power_down,
  output logic [6:0]      o_supply_en,
  output logic            o_seq_busy,
  output logic            o_seq_done
);

  // Whole state of the sequencer in one word.
  typedef struct packed
  {
    seq_state_t  st;
    logic [2:0]  level;
    logic [15:0] cnt;
    logic [6:0]  en;
    logic        busy;
    logic        done;
    logic        rvalid;
  } seq_regs_t;

  seq_regs_t  sq_r;
  seq_regs_t  sq_nxt;
  order_vec_t off_order;
  addr_dec_t  dec;
  logic       wr_ok;
  logic [6:0] at_level;
  logic       all_zero;

  if (P_SUPPLIES != NUM_SUPPLIES)
  begin : g_bad_supplies
    $error("pdo_sequencer supports exactly seven supplies");
  end
  if ((P_STEP_CYCLES < 1) || (P_STEP_CYCLES > 65535))
  begin : g_bad_step
    $error("pdo_sequencer step count must lie in 1..65535");
  end

  // Writes are refused outside system-on and while a power-down runs,
  // so the sequencer never sees its order change under its feet.
  assign dec   = decode_addr(i_reg.addr);
  assign wr_ok = i_reg.wr && dec.writable && i_system_on && (sq_r.st == SEQ_IDLE);

  pdo_order_store #(
    .P_SUPPLIES   (P_SUPPLIES)
  ) u_store (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_clk_en     (i_clk_en),
    .i_fuse_order (i_fuse_order),
    .i_wr_en      (wr_ok),
    .i_rd_en      (i_reg.rd),
    .i_addr       (i_reg.addr),
    .i_wdata      (i_reg.wdata),
    .o_rdata      (o_reg_rdata),
    .o_off_order  (off_order)
  );

  // Per-supply match of its order field against the current step level.
  for (genvar g = 0; g < NUM_SUPPLIES; g++)
  begin : g_match
    assign at_level[g] = (off_order[g] == sq_r.level);
  end

  // A supply whose field is nonzero keeps the sequencer in play.
  assign all_zero = (off_order == '0);

  // The bottom level closes the run; both the step and the wait state
  // test it, so the test lives in one place.
  function automatic logic at_bottom(input logic [2:0] lvl);
    return (lvl == `PDO_ORDER_RESET);
  endfunction

  // Sequencer next state.
  always_comb
  begin
    sq_nxt        = sq_r;
    sq_nxt.done   = 1'b0;
    sq_nxt.rvalid = i_reg.rd;
    case (sq_r.st)
      // Idle: a power-down request beats a power-up request in the same cycle.
      SEQ_IDLE:
      begin
        if (i_power_down)
        begin
          if (all_zero)
          begin
            sq_nxt.en   = '0; // Bypass: every supply drops in the same cycle.
            sq_nxt.done = 1'b1;
          end
          else
          begin
            sq_nxt.st    = SEQ_STEP;
            sq_nxt.level = `PDO_TOP_LEVEL;
            sq_nxt.busy  = 1'b1;
          end
        end
        else if (i_supplies_on)
        begin
          sq_nxt.en = '1;
        end
      end
      SEQ_STEP:
      begin
        // Supplies sharing a level go off together; empty levels cost one cycle only.
        sq_nxt.en = sq_r.en & ~at_level;
        if ((at_level & sq_r.en) != '0)
        begin
          sq_nxt.st  = SEQ_WAIT;
          sq_nxt.cnt = 16'(P_STEP_CYCLES - 1);
        end
        else if (at_bottom(sq_r.level))
        begin
          sq_nxt.st   = SEQ_IDLE;
          sq_nxt.busy = 1'b0;
          sq_nxt.done = 1'b1;
        end
        else
        begin
          sq_nxt.level = sq_r.level - 3'h1; // Descending order.
        end
      end
      // Wait: hold the enables for the pause, then move one level down, or finish the run after level 0.
      SEQ_WAIT:
      begin
        if (sq_r.cnt != 16'h0000)
        begin
          sq_nxt.cnt = sq_r.cnt - 16'h0001;
        end
        else if (at_bottom(sq_r.level))
        begin
          sq_nxt.st   = SEQ_IDLE;
          sq_nxt.busy = 1'b0;
          sq_nxt.done = 1'b1;
        end
        else
        begin
          sq_nxt.st    = SEQ_STEP;
          sq_nxt.level = sq_r.level - 3'h1;
        end
      end
      // An unused state code falls back to idle rather than hanging.
      default:
      begin
        sq_nxt.st   = SEQ_IDLE;
        sq_nxt.busy = 1'b0;
      end
    endcase
  end

  // State register; the clock enable freezes everything.
  // Reset is synchronous and wins over the enable, so a frozen block can still be cleared.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sq_r.st     <= SEQ_IDLE;
      sq_r.level  <= `PDO_ORDER_RESET;
      sq_r.cnt    <= 16'h0000;
      sq_r.en     <= 7'h00;
      sq_r.busy   <= 1'b0;
      sq_r.done   <= 1'b0;
      sq_r.rvalid <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sq_r <= sq_nxt;
    end
  end

  // All outputs but o_reg_rdata come straight from the state word; the read byte comes from the order store.
  assign o_reg_rvalid = sq_r.rvalid;
  assign o_supply_en  = sq_r.en;
  assign o_seq_busy   = sq_r.busy;
  assign o_seq_done   = sq_r.done;

endmodule
